// >>> hdl/soi_pkg.sv
// constants, field layouts and types of the safety output interlock
package soi_pkg;
  // ==========================================================
  // clock and slow tick
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 17;
  localparam int CNT_W = 12;
  // ==========================================================
  // acknowledge high phase window, 0.1 s to 4 s
  localparam int ACK_MIN_MS = 100;
  localparam int ACK_MAX_MS = 4000;
  localparam int ACK_MIN_TICKS = (ACK_MIN_MS * TICK_HZ + 999) / 1000;
  localparam int ACK_MAX_TICKS = (ACK_MAX_MS * TICK_HZ) / 1000;
  // contactor feedback window
  localparam int FB_WINDOW_MS = 300;
  localparam int FB_WINDOW_TICKS = (FB_WINDOW_MS * TICK_HZ) / 1000;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_BEAM_CODE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ctrl fields
  localparam int CTRL_W = 7;
  localparam int CTRL_FAULT_CLR = 8;
  localparam logic [6:0] CTRL_RESET = 7'h01;
  localparam logic [1:0] MUTE_NONE = 2'h0;
  localparam logic [1:0] MUTE_TWO = 2'h1;
  localparam logic [1:0] MUTE_FOUR_SEQ = 2'h2;
  localparam logic [1:0] MUTE_FOUR_TIME = 2'h3;
  // status bits
  localparam int ST_W = 7;
  // interrupt bits
  localparam int IRQ_ON = 0;
  localparam int IRQ_OFF = 1;
  localparam int IRQ_ACK_OK = 2;
  localparam int IRQ_ACK_BAD = 3;
  localparam int IRQ_FAULT = 4;
  localparam int IRQ_CFG = 5;
  localparam int IRQ_W = 6;
  // beam code
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_RESET = 4'h0;
  // ==========================================================
  // types
  typedef struct packed {
    logic [1:0] muting_kind;
    logic cascade_en;
    logic range_low;
    logic coding_en;
    logic fb_check_en;
    logic interlock_en;
  } soi_ctrl_t;
  typedef struct packed {
    logic scan_end;
    logic sync;
    logic light;
    logic valid;
    logic [CODE_W-1:0] code;
  } soi_beam_t;
  typedef enum logic [1:0] {ST_LOCKED, ST_ON, ST_AUTO_OFF, ST_FAULT} soi_out_state_t;
  typedef enum logic [1:0] {AK_WAIT_LOW, AK_ARMED, AK_HIGH} soi_ack_state_t;
endpackage

// >>> hdl/soi_ack_check.sv
// acknowledge pulse checker for the restart interlock
`timescale 1ns/10ps
module soi_ack_check #(
  parameter int ACK_MIN_TICKS = soi_pkg::ACK_MIN_TICKS,
  parameter int ACK_MAX_TICKS = soi_pkg::ACK_MAX_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // slow tick and key level
  input wire logic tick,
  input wire logic ack_level,
  // verdicts
  output logic accept_pulse,
  output logic reject_pulse
);
  import soi_pkg::*;
  soi_ack_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic accept_nxt, reject_nxt;
  wire logic in_window = (cnt_r >= CNT_W'(ACK_MIN_TICKS)) && (cnt_r <= CNT_W'(ACK_MAX_TICKS));

  // low, high, low sequence with timed high phase
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    accept_nxt = 1'b0;
    reject_nxt = 1'b0;
    case (state_r)
      AK_WAIT_LOW: begin
        if (!ack_level) state_nxt = AK_ARMED;
      end
      AK_ARMED: begin
        if (ack_level) begin
          state_nxt = AK_HIGH;
          cnt_nxt = '0;
        end
      end
      AK_HIGH: begin
        if (tick && cnt_r <= CNT_W'(ACK_MAX_TICKS)) cnt_nxt = cnt_r + 1'b1;
        if (!ack_level) begin
          state_nxt = AK_ARMED;
          accept_nxt = in_window;
          reject_nxt = !in_window;
        end
      end
      default: state_nxt = AK_WAIT_LOW;
    endcase
  end

  // state and verdict flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= AK_WAIT_LOW;
      cnt_r <= '0;
      accept_pulse <= 1'b0;
      reject_pulse <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      accept_pulse <= accept_nxt;
      reject_pulse <= reject_nxt;
    end
  end
endmodule

// >>> hdl/soi_beam_filter.sv
// beam code filter and synchronisation of the receiver scan
`timescale 1ns/10ps
module soi_beam_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic coding_en,
  input wire logic [soi_pkg::CODE_W-1:0] own_code,
  // beam samples
  input wire soi_pkg::soi_beam_t beam,
  // result
  output logic field_blocked,
  output logic synced
);
  import soi_pkg::*;
  logic dark_acc_r, sync_seen_r;
  // foreign beams count as not received
  wire logic own_w = beam.valid && (!coding_en || beam.code == own_code);
  wire logic sync_hit = own_w && beam.sync && beam.light;
  wire logic unsynced = coding_en && !synced && !sync_hit;
  wire logic dark_w = beam.valid && (!own_w || !beam.light || unsynced);

  // accumulate one scan and publish it at its end; synced also rises at once on a sync hit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dark_acc_r <= 1'b0;
      sync_seen_r <= 1'b0;
      field_blocked <= 1'b1;
      synced <= 1'b0;
    end else if (beam.scan_end) begin
      field_blocked <= dark_acc_r | dark_w;
      synced <= !coding_en | sync_seen_r | sync_hit;
      dark_acc_r <= 1'b0;
      sync_seen_r <= 1'b0;
    end else begin
      dark_acc_r <= dark_acc_r | dark_w;
      sync_seen_r <= sync_seen_r | sync_hit;
      if (sync_hit) synced <= 1'b1;
    end
  end
endmodule

// >>> hdl/soi_top.sv
// safety output interlock with an axi4-lite register slave
// Operation
// - in automatic mode the outputs go off while the field is interrupted and back on after.
// - with the restart interlock disabled the block runs in automatic mode by itself.
// - with the interlock enabled the outputs stay off after an interruption until a valid ack.
// - the locked state holds over a power cycle, so outputs come up off.
// - release needs the ack input low, then high, then low, in that order only.
// - the high phase of the ack must last from 0.1 s to 4 s to count.
// - with feedback checking on, each output change must be matched by feedback within a window.
// - a feedback miss forces a safe state with outputs off and an error shown.
// - with coding on only beams with the own code are evaluated.
// - first and last beams are sync beams and either one alone synchronises.
// - coding is an on/off setting which emitter and receiver must share.
// - the emitter range has a high default and a low short-distance option.
// - cascading with a four-sensor muting variant is rejected as a configuration.
`timescale 1ns/10ps
module soi_top #(
  parameter int TICK_CYCLES = soi_pkg::TICK_CYCLES,
  parameter int ACK_MIN_TICKS = soi_pkg::ACK_MIN_TICKS,
  parameter int ACK_MAX_TICKS = soi_pkg::ACK_MAX_TICKS,
  parameter int FB_WINDOW_TICKS = soi_pkg::FB_WINDOW_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [soi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [soi_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sensing side
  input wire soi_pkg::soi_beam_t beam,
  input wire logic restart_interlock_ack,
  input wire logic contactor_feedback,
  // machine side
  output logic [1:0] safety_switch_outputs,
  output logic emitter_range_low,
  output logic fault_out,
  output logic irq
);
  import soi_pkg::*;

  // ==========================================================
  // registers and state
  soi_ctrl_t ctrl_r;
  logic [CODE_W-1:0] code_r;
  logic [IRQ_W-1:0] int_stat_r, int_mask_r;
  soi_out_state_t state_r, state_nxt;
  logic on_r, fault_r, fb_pend_r, cfg_rej_r;
  logic [CNT_W-1:0] fb_cnt_r;
  logic [TICK_W-1:0] div_r;
  logic tick_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_held_r, w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic ack_ok, ack_bad, field_blocked, synced;

  // ==========================================================
  // slow tick divider
  wire logic div_end = div_r == TICK_W'(TICK_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_end ? '0 : div_r + 1'b1;
      tick_r <= div_end;
    end
  end

  // ==========================================================
  // sub blocks
  // window counts follow the top parameters so a short tick shrinks them together
  soi_ack_check #(.ACK_MIN_TICKS(ACK_MIN_TICKS), .ACK_MAX_TICKS(ACK_MAX_TICKS)) u_ack (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_r),
    .ack_level(restart_interlock_ack),
    .accept_pulse(ack_ok),
    .reject_pulse(ack_bad)
  );
  soi_beam_filter u_beam (
    .aclk(aclk),
    .aresetn(aresetn),
    .coding_en(ctrl_r.coding_en),
    .own_code(code_r),
    .beam(beam),
    .field_blocked(field_blocked),
    .synced(synced)
  );

  // ==========================================================
  // configuration check and field state
  wire logic four_sensor = ctrl_r.muting_kind == MUTE_FOUR_SEQ ||
                           ctrl_r.muting_kind == MUTE_FOUR_TIME;
  wire logic cfg_bad = ctrl_r.cascade_en && four_sensor;
  wire logic field_ok = !field_blocked && synced && !cfg_rej_r;

  // ==========================================================
  // axi write path
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire logic wr_ctrl = wr_go && awaddr_r == REG_CTRL;
  wire logic wr_stat = wr_go && awaddr_r == REG_INT_STATUS;
  wire logic wr_mask = wr_go && awaddr_r == REG_INT_MASK;
  wire logic wr_code = wr_go && awaddr_r == REG_BEAM_CODE;
  wire logic wr_ro = wr_go && awaddr_r == REG_STATUS;
  wire logic wr_hit = wr_ctrl | wr_stat | wr_mask | wr_code | wr_ro;
  wire logic fault_clr = wr_ctrl && wstrb_r[1] && wdata_r[CTRL_FAULT_CLR];

  // address and data holding, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
      aw_held_r <= wr_go ? 1'b0 : aw_held_r | aw_take;
      w_held_r <= wr_go ? 1'b0 : w_held_r | w_take;
    end
  end

  // write handshake outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      int_mask_r <= '0;
      code_r <= CODE_RESET;
    end else begin
      if (wr_ctrl && wstrb_r[0]) ctrl_r <= wdata_r[CTRL_W-1:0];
      if (wr_mask && wstrb_r[0]) int_mask_r <= wdata_r[IRQ_W-1:0];
      if (wr_code && wstrb_r[0]) code_r <= wdata_r[CODE_W-1:0];
    end
  end

  // ==========================================================
  // axi read path
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [ST_W-1:0] status_w = {contactor_feedback, synced, field_blocked, cfg_rej_r,
                                     fault_r, state_r == ST_LOCKED, on_r};
  wire logic rd_hit = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STATUS ||
                      s_axi_araddr == REG_INT_STATUS || s_axi_araddr == REG_INT_MASK ||
                      s_axi_araddr == REG_BEAM_CODE;
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      REG_CTRL: rd_mux = {25'h0, ctrl_r};
      REG_STATUS: rd_mux = {25'h0, status_w};
      REG_INT_STATUS: rd_mux = {26'h0, int_stat_r};
      REG_INT_MASK: rd_mux = {26'h0, int_mask_r};
      REG_BEAM_CODE: rd_mux = {28'h0, code_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // read handshake outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ON: begin
        if (fault_r) state_nxt = ST_FAULT;
        else if (!field_ok && ctrl_r.interlock_en) state_nxt = ST_LOCKED;
        else if (!field_ok) state_nxt = ST_AUTO_OFF;
      end
      ST_AUTO_OFF: begin
        if (fault_r) state_nxt = ST_FAULT;
        else if (ctrl_r.interlock_en) state_nxt = ST_LOCKED;
        else if (field_ok) state_nxt = ST_ON;
      end
      ST_LOCKED: begin
        if (fault_r) state_nxt = ST_FAULT;
        else if (!ctrl_r.interlock_en) state_nxt = ST_AUTO_OFF;
        else if (ack_ok && field_ok) state_nxt = ST_ON;
      end
      ST_FAULT: begin
        if (!fault_r) state_nxt = ST_LOCKED;
      end
      default: state_nxt = ST_LOCKED;
    endcase
  end

  // state, outputs and config reject
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_LOCKED;
      on_r <= 1'b0;
      safety_switch_outputs <= 2'h0;
      cfg_rej_r <= 1'b0;
      emitter_range_low <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      on_r <= state_nxt == ST_ON;
      safety_switch_outputs <= {2{state_nxt == ST_ON}};
      cfg_rej_r <= cfg_bad;
      emitter_range_low <= ctrl_r.range_low;
      fault_out <= fault_r;
    end
  end

  // ==========================================================
  // contactor feedback monitor, nc contacts read high when released
  wire logic on_edge = on_r != (state_nxt == ST_ON);
  wire logic fb_match = contactor_feedback == !on_r;
  wire logic fb_miss = fb_pend_r && !fb_match && tick_r && fb_cnt_r == '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_pend_r <= 1'b0;
      fb_cnt_r <= '0;
      fault_r <= 1'b0;
    end else begin
      if (on_edge && ctrl_r.fb_check_en) begin
        fb_pend_r <= 1'b1;
        fb_cnt_r <= CNT_W'(FB_WINDOW_TICKS);
      end else if (!ctrl_r.fb_check_en || fb_match || fb_miss) begin
        fb_pend_r <= 1'b0;
      end else if (tick_r && fb_cnt_r != '0) begin
        fb_cnt_r <= fb_cnt_r - 1'b1;
      end
      if (fb_miss) fault_r <= 1'b1;
      else if (fault_clr) fault_r <= 1'b0;
    end
  end

  // ==========================================================
  // sticky interrupt status, set wins over write-one clear
  logic [IRQ_W-1:0] ev_w;
  always_comb begin
    ev_w = '0;
    ev_w[IRQ_ON] = !on_r && state_nxt == ST_ON;
    ev_w[IRQ_OFF] = on_r && state_nxt != ST_ON;
    ev_w[IRQ_ACK_OK] = ack_ok;
    ev_w[IRQ_ACK_BAD] = ack_bad;
    ev_w[IRQ_FAULT] = fb_miss;
    ev_w[IRQ_CFG] = cfg_bad && !cfg_rej_r;
  end
  wire logic [IRQ_W-1:0] clr_w = (wr_stat && wstrb_r[0]) ? wdata_r[IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~clr_w) | ev_w;
      irq <= |(((int_stat_r & ~clr_w) | ev_w) & int_mask_r);
    end
  end
endmodule

// >>> verification/soi_props.sv
// port checker of the safety output interlock
`timescale 1ns/10ps
module soi_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // machine side
  input wire logic restart_interlock_ack,
  input wire logic contactor_feedback,
  input wire logic [1:0] safety_switch_outputs,
  input wire logic fault_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // assertions
  outs_pair_a: assert property (safety_switch_outputs[0] == safety_switch_outputs[1])
    else $error("output pair split");
  reset_off_a: assert property ($rose(aresetn) |-> (safety_switch_outputs == 2'h0) [*3])
    else $error("outputs on after reset");
  fault_off_a: assert property (fault_out |=> safety_switch_outputs == 2'h0)
    else $error("outputs on during fault");
  fault_cause_a: assert property ($rose(fault_out) |->
    $past(contactor_feedback) == $past(safety_switch_outputs[0]))
    else $error("fault without feedback mismatch");
  fault_hold_a: assert property (fault_out && !s_axi_wvalid && !$past(s_axi_wvalid)
    && !$past(s_axi_wvalid, 2) && !s_axi_bvalid && !$past(s_axi_bvalid) |=> fault_out)
    else $error("fault dropped without clear");
  ack_low_a: assert property ($rose(safety_switch_outputs[0]) |->
    !restart_interlock_ack && !$past(restart_interlock_ack))
    else $error("outputs on while key high");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response not retired");
  // main scenarios
  cover property ($rose(fault_out));
  cover property ($rose(safety_switch_outputs[0]));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind soi_top soi_props soi_props_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .restart_interlock_ack, .contactor_feedback, .safety_switch_outputs, .fault_out);

// >>> verification/soi_partner.sv
// contactor pair and acknowledge key in front of the interlock
`timescale 1ns/10ps
module soi_partner #(
  parameter int FB_DELAY = 6
) (
  // clock
  input wire logic aclk,
  // coils and welded contact
  input wire logic [1:0] coil,
  input wire logic weld,
  // key and nc feedback
  output logic key,
  output logic feedback
);
  int cnt = 0;
  // key released, contactor released at start
  initial begin
    key = 1'b0;
    feedback = 1'b1;
  end
  // nc contact follows the coils after a delay; a weld freezes it
  always @(posedge aclk) begin
    if (weld || feedback != coil[0]) begin
      cnt <= 0;
    end else if (cnt == FB_DELAY) begin
      feedback <= !coil[0];
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // one press: low, high for hold cycles, low again
  task automatic press(input int hold);
    key <= 1'b0;
    repeat (2) @(posedge aclk);
    key <= 1'b1;
    repeat (hold) @(posedge aclk);
    key <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// >>> verification/safety_output_interlock_tb.sv
// self-checking bench of the safety output interlock
`timescale 1ns/10ps
module safety_output_interlock_tb;
  import soi_pkg::*;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, weld;
  soi_beam_t beam;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, safety_switch_outputs;
  logic [31:0] s_axi_rdata;
  logic restart_interlock_ack, contactor_feedback, emitter_range_low, fault_out;
  int fails = 0;
  int comparisons = 0;
  // clock of 8 ns
  always #4 aclk = ~aclk;
  // design with short tick and windows
  soi_top #(.TICK_CYCLES(10), .ACK_MIN_TICKS(3), .ACK_MAX_TICKS(8), .FB_WINDOW_TICKS(4))
  soi_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .beam, .restart_interlock_ack, .contactor_feedback, .safety_switch_outputs,
    .emitter_range_low, .fault_out, .irq);
  soi_partner soi_partner_i (.aclk, .coil(safety_switch_outputs), .weld,
    .key(restart_interlock_ack), .feedback(contactor_feedback));
  // ==========================================================
  // shared tasks
  task automatic complete_run;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout;
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) timeout();
    check(s_axi_bresp, er, "write response");
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) timeout();
    check(s_axi_rdata, ed, "read data");
    check(s_axi_rresp, er, "read response");
    @(posedge aclk);
  endtask
  // one scan of three beams, the last one ends the scan
  task automatic scan(input logic lit, input logic [3:0] code, input logic first_sync);
    beam <= '{1'b0, first_sync, lit, 1'b1, code};
    @(posedge aclk);
    beam <= '{1'b0, 1'b0, lit, 1'b1, code};
    @(posedge aclk);
    beam <= '{1'b1, 1'b1, lit, 1'b1, code};
    @(posedge aclk);
    beam <= '0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic outs(input logic v, input string msg);
    int n;
    for (n = 0; n < 40 && safety_switch_outputs !== {v, v}; n++) @(posedge aclk);
    if (n == 40) timeout();
    check(safety_switch_outputs, {v, v}, msg);
  endtask
  task automatic stay_off(input string msg);
    repeat (40) @(posedge aclk);
    check(safety_switch_outputs, 32'h0, msg);
  endtask
  task automatic later(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ==========================================================
  // scenarios
  task automatic reset_values;
    check(safety_switch_outputs, 32'h0, "outputs on after reset");
    check(emitter_range_low, 32'h0, "range not high");
    rd(REG_CTRL, {25'h0, CTRL_RESET}, RESP_OKAY);
    rd(REG_INT_MASK, 32'h0, RESP_OKAY);
    rd(REG_BEAM_CODE, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(REG_INT_MASK, 32'h3f, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(REG_INT_MASK, 32'h0, RESP_OKAY);
    wr(8'h14, 32'hff, RESP_SLVERR);
    wr(REG_CTRL, 32'h9, RESP_OKAY);
    later(3);
    check(emitter_range_low, 32'h1, "range not low");
  endtask
  task automatic interlock;
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_INT_MASK, 32'h8, RESP_OKAY);
    scan(1'b1, 4'h0, 1'b1);
    stay_off("restarted without key");
    check(irq, 32'h0, "irq without event");
    soi_partner_i.press(10);
    stay_off("short press released");
    check(irq, 32'h1, "no irq on rejected press");
    wr(REG_INT_MASK, 32'h0, RESP_OKAY);
    later(3);
    check(irq, 32'h0, "masked irq high");
    wr(REG_INT_MASK, 32'h8, RESP_OKAY);
    wr(REG_INT_STATUS, 32'h8, RESP_OKAY);
    later(3);
    check(irq, 32'h0, "irq not cleared");
    soi_partner_i.press(120);
    stay_off("long press released");
    wr(REG_INT_MASK, 32'h0, RESP_OKAY);
    soi_partner_i.press(50);
    outs(1'b1, "valid press refused");
    scan(1'b0, 4'h0, 1'b1);
    outs(1'b0, "outputs on with field broken");
    scan(1'b1, 4'h0, 1'b1);
    stay_off("auto restart after break");
    soi_partner_i.press(50);
    outs(1'b1, "valid press refused");
    aresetn <= 1'b0;
    later(2);
    aresetn <= 1'b1;
    later(1);
    scan(1'b1, 4'h0, 1'b1);
    stay_off("lock lost over power cycle");
    soi_partner_i.press(50);
    outs(1'b1, "press after power cycle refused");
  endtask
  task automatic auto_mode;
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    scan(1'b0, 4'h0, 1'b1);
    outs(1'b0, "on with field broken");
    scan(1'b1, 4'h0, 1'b1);
    outs(1'b1, "no automatic restart");
  endtask
  task automatic coding;
    wr(REG_BEAM_CODE, 32'h5, RESP_OKAY);
    wr(REG_CTRL, 32'h4, RESP_OKAY);
    scan(1'b1, 4'h5, 1'b1);
    outs(1'b1, "own code refused");
    scan(1'b1, 4'h3, 1'b1);
    outs(1'b0, "foreign code taken");
    scan(1'b1, 4'h5, 1'b0);
    rd(REG_STATUS, 32'h70, RESP_OKAY);
    scan(1'b1, 4'h5, 1'b0);
    outs(1'b1, "single sync beam refused");
  endtask
  task automatic contactor;
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    wr(REG_INT_MASK, 32'h10, RESP_OKAY);
    scan(1'b0, 4'h0, 1'b1);
    outs(1'b0, "on with field broken");
    scan(1'b1, 4'h0, 1'b1);
    outs(1'b1, "no restart with feedback on");
    later(60);
    check(fault_out, 32'h0, "fault with good feedback");
    weld <= 1'b1;
    scan(1'b0, 4'h0, 1'b1);
    outs(1'b0, "on with field broken");
    later(60);
    check(fault_out, 32'h1, "welded contact missed");
    check(irq, 32'h1, "no fault irq");
    weld <= 1'b0;
    scan(1'b1, 4'h0, 1'b1);
    stay_off("restart during fault");
    wr(REG_CTRL, 32'h102, RESP_OKAY);
    wr(REG_INT_STATUS, 32'h10, RESP_OKAY);
    later(3);
    check(fault_out, 32'h0, "fault not cleared");
    check(irq, 32'h0, "fault irq not cleared");
    scan(1'b1, 4'h0, 1'b1);
    outs(1'b1, "no restart after clear");
  endtask
  task automatic config_reject;
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, {25'h0, k[1:0], 5'h10}, RESP_OKAY);
      scan(1'b1, 4'h0, 1'b1);
      outs(k < 2, "cascade with muting");
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    // inputs idle and reset asserted from the start
    aresetn <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    beam <= '0;
    weld <= 1'b0;
    later(8);
    aresetn <= 1'b1;
    later(1);
    reset_values();
    interlock();
    auto_mode();
    coding();
    contactor();
    config_reject();
    complete_run();
  end
endmodule
